/* File: uart_md_pkg.sv */
// package of constants for the multidrop uart extension
package uart_md_pkg;
   localparam int DATA_WIDTH = 9;
   localparam int FIFO_DEPTH = 8;
   localparam logic [4:0] OVERSAMPLE = 5'h10;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [1:0] SCHEME_ALL = 2'h0;
   localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
   localparam logic [1:0] SCHEME_MATCH_IRQ = 2'h2;
   localparam logic [1:0] SCHEME_MATCH_QUIET = 2'h3;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [10:0] SHIFT_IDLE = 11'h7FF;
   localparam logic [3:0] BIT_RESET = 4'h0;
   localparam logic [3:0] TICK_RESET = 4'h0;
endpackage : uart_md_pkg

/* File: uart_md_fifo.sv */
// parameterised fifo with valid/ready on both sides
`timescale 1ns/100ps
module uart_md_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clocking
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   always_comb
   begin
      push = i_in_valid && (count < (AW+1)'(DEPTH));
      pop = (count != '0) && i_out_ready;
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else if (i_ce)
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage has no reset: contents are only read behind a valid count
   always_ff @(posedge i_clk)
   begin
      if (i_ce && push)
      begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_comb
   begin
      o_in_ready = (count < (AW+1)'(DEPTH));
      o_out_valid = (count != '0);
      o_out_data = mem[rd_ptr];
   end
endmodule : uart_md_fifo

/* File: uart_multidrop_de_brg.sv */
// multidrop uart extension: 9-bit tx/rx, address filter, drive enable, divider timer
// What this block does
// - nine-bit mode sends marker bit after eight data bits, before stop bits
// - in nine-bit mode the ninth slot carries the marker, parity enable ignored
// - multidrop schemes need nine-bit mode on; two-bit field picks scheme
// - scheme 01: address bytes interrupt, data bytes never do
// - scheme 00 with nine-bit mode: every received byte interrupts
// - scheme 10: compare address, drop mismatched address and its data
// - scheme 10: matching address interrupts, following data bytes interrupt too
// - compare schemes flag first data byte of each matched frame
// - scheme 11: like 10 but matched address bytes give no interrupt
// - drive enable rises on tx write, about one bit period (sixteen ticks of setup) before start
// - drive enable covers frame up to last stop bit, drops one clock after that stop bit ends
// - back to back characters keep drive enable asserted between them
// - polarity bit selects active high or inverted drive enable
// - transmit interrupt when holding register empties after first bit sent
// - writing transmit data clears holding empty flag
// - rx interrupt on data (maskable), break, overrun, framing error
// - on overrun keep unread byte, hide overrun and break until read
// - after read show overrun, break, data available; second read clears
// - with divider timer bit set and tx and rx both off, receiver interrupt on each divider reload
// - bit rate is clock divided by sixteen times the 16-bit divisor
// - with tx and rx off and timer bit set, divider interrupts each count
// - reading receive data clears parity and framing flags, and available and break unless held by a pending overrun
// - marker status holds last marker bit, cleared by receive data read
`timescale 1ns/100ps
module uart_multidrop_de_brg (
   // clocking
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // configuration
   input wire logic i_transmitter_on,
   input wire logic i_receiver_on,
   input wire logic i_parity_enable,
   input wire logic i_parity_odd,
   input wire logic i_two_stop,
   input wire logic i_ninebit_mode_enable,
   input wire logic [1:0] i_multidrop_scheme_select,
   input wire logic i_tx_marker_bit,
   input wire logic [7:0] i_address_compare,
   input wire logic i_drive_enable_polarity,
   input wire logic i_divider_timer_enable,
   input wire logic i_rx_data_irq_enable,
   input wire logic [15:0] i_bit_rate_divider,
   // processor data access
   input wire logic i_tx_write,
   input wire logic [7:0] i_tx_data,
   input wire logic i_rx_read,
   // serial line
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_transceiver_drive_enable,
   // status
   output logic [7:0] o_rx_data,
   output logic o_rx_byte_available,
   output logic o_parity_error,
   output logic o_overrun_error,
   output logic o_framing_error,
   output logic o_line_break_flag,
   output logic o_tx_holding_empty,
   output logic o_tx_empty,
   output logic o_rx_marker_bit,
   output logic o_first_byte_of_frame,
   // interrupts
   output logic o_tx_irq,
   output logic o_rx_irq
);
   // divider
   logic [15:0] div_cnt;
   logic [15:0] next_div_cnt;
   logic div_tick;
   logic timer_mode;
   // tx
   logic [7:0] hold_data;
   logic hold_marker;
   logic hold_full;
   logic [10:0] tx_shift;
   logic [3:0] tx_bits;
   logic [3:0] tx_tick;
   logic tx_busy;
   logic tx_setup;
   logic de_active;
   logic [7:0] next_hold_data;
   logic next_hold_marker;
   logic next_hold_full;
   logic [10:0] next_tx_shift;
   logic [3:0] next_tx_bits;
   logic [3:0] next_tx_tick;
   logic next_tx_busy;
   logic next_tx_setup;
   logic next_de_active;
   logic tx_first_bit_done;
   // rx
   logic rxd_meta;
   logic rxd_sync;
   logic rx_busy;
   logic [3:0] rx_tick;
   logic [3:0] rx_bits;
   logic [9:0] rx_shift;
   logic next_rx_busy;
   logic [3:0] next_rx_tick;
   logic [3:0] next_rx_bits;
   logic [9:0] next_rx_shift;
   logic rx_done;
   logic [8:0] rx_char;
   logic rx_frame_bad;
   logic rx_par_bad;
   // fifo stage between the deserialiser and the status registers
   logic fifo_valid;
   logic [8:0] fifo_data;
   logic fifo_ready;
   logic fifo_in_ready;
   logic [2:0] rx_err;
   logic [2:0] next_rx_err;
   // filter and status
   logic frame_matched;
   logic want_first;
   logic next_frame_matched;
   logic next_want_first;
   logic [7:0] next_rx_data;
   logic next_avail;
   logic next_pe;
   logic next_oe;
   logic next_fe;
   logic next_brk;
   logic next_marker;
   logic next_first;
   logic pend_oe;
   logic pend_brk;
   logic next_pend_oe;
   logic next_pend_brk;
   logic next_rx_irq;
   logic next_tx_irq;

   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      parity_of = (^d) ^ odd;
   endfunction : parity_of

   // shift edges from the end of the start bit to the end of the last stop bit
   function automatic logic [3:0] tx_frame_len(input logic nine, input logic par, input logic two);
      tx_frame_len = ((nine || par) ? 4'hB : 4'hA) + (two ? 4'h1 : 4'h0);
   endfunction : tx_frame_len

   // divider: reloads each time it reaches one, giving clk/divisor ticks
   always_comb
   begin
      timer_mode = i_divider_timer_enable && !i_transmitter_on && !i_receiver_on;
      div_tick = (div_cnt <= 16'h0001) && (i_bit_rate_divider != uart_md_pkg::DIVISOR_RESET);
      next_div_cnt = div_tick ? i_bit_rate_divider : div_cnt - 16'h0001;
      if (i_bit_rate_divider == uart_md_pkg::DIVISOR_RESET)
      begin
         next_div_cnt = uart_md_pkg::DIVISOR_RESET;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         div_cnt <= uart_md_pkg::DIVISOR_RESET;
      end
      else if (i_ce)
      begin
         div_cnt <= next_div_cnt;
      end
   end

   // transmitter: 16 divider ticks per bit
   always_comb
   begin
      next_hold_data = hold_data;
      next_hold_marker = hold_marker;
      next_hold_full = hold_full;
      next_tx_shift = tx_shift;
      next_tx_bits = tx_bits;
      next_tx_tick = tx_tick;
      next_tx_busy = tx_busy;
      next_tx_setup = tx_setup;
      tx_first_bit_done = 1'b0;
      if (i_tx_write)
      begin
         next_hold_data = i_tx_data;
         next_hold_marker = i_tx_marker_bit;
         next_hold_full = 1'b1;
      end
      if (div_tick && (tx_busy || tx_setup))
      begin
         next_tx_tick = tx_tick + 4'h1;
      end
      if (!tx_busy && !tx_setup && hold_full && i_transmitter_on)
      begin
         // one whole bit of setup with drive enable on before the start bit
         next_tx_setup = 1'b1;
         next_tx_tick = uart_md_pkg::TICK_RESET;
      end
      else if (tx_setup && div_tick && tx_tick == 4'hF)
      begin
         next_tx_setup = 1'b0;
         next_tx_busy = 1'b1;
         // holding stays full until the start bit has gone out
         next_tx_shift = {2'b11,
            i_ninebit_mode_enable ? hold_marker : parity_of(hold_data, i_parity_odd),
            hold_data};
         next_tx_bits = tx_frame_len(i_ninebit_mode_enable, i_parity_enable, i_two_stop);
         if (!i_ninebit_mode_enable && !i_parity_enable)
         begin
            next_tx_shift = {3'b111, hold_data};
         end
      end
      else if (tx_busy && div_tick && tx_tick == 4'hF)
      begin
         // the start bit has just gone: the holding register is free from here on
         tx_first_bit_done = (tx_bits == tx_frame_len(i_ninebit_mode_enable, i_parity_enable, i_two_stop));
         if (tx_first_bit_done)
         begin
            next_hold_full = i_tx_write;
         end
         if (tx_bits == 4'h1)
         begin
            next_tx_busy = 1'b0;
         end
         else
         begin
            next_tx_bits = tx_bits - 4'h1;
         end
      end
   end

   // drive enable spans setup, busy and one clock after; back to back keeps it high
   always_comb
   begin
      next_de_active = next_tx_busy || next_tx_setup || tx_busy;
      // the write itself raises drive enable, one clock before the sixteen setup ticks begin
      if (!next_tx_busy && !next_tx_setup && next_hold_full && i_transmitter_on)
      begin
         next_de_active = 1'b1;
      end
      next_tx_irq = !next_hold_full;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         hold_data <= uart_md_pkg::BYTE_RESET;
         hold_marker <= 1'b0;
         hold_full <= 1'b0;
         tx_shift <= uart_md_pkg::SHIFT_IDLE;
         tx_bits <= uart_md_pkg::BIT_RESET;
         tx_tick <= uart_md_pkg::TICK_RESET;
         tx_busy <= 1'b0;
         tx_setup <= 1'b0;
         de_active <= 1'b0;
         o_txd <= 1'b1;
         o_transceiver_drive_enable <= 1'b0;
         o_tx_holding_empty <= 1'b1;
         o_tx_empty <= 1'b1;
         o_tx_irq <= 1'b0;
      end
      else if (i_ce)
      begin
         hold_data <= next_hold_data;
         hold_marker <= next_hold_marker;
         hold_full <= next_hold_full;
         tx_bits <= next_tx_bits;
         tx_tick <= next_tx_tick;
         tx_busy <= next_tx_busy;
         tx_setup <= next_tx_setup;
         de_active <= next_de_active;
         // start bit is driven straight onto o_txd when busy begins; the shift word holds no start bit
         if (next_tx_busy && !tx_busy)
         begin
            tx_shift <= next_tx_shift;
            o_txd <= 1'b0;
         end
         else if (tx_busy && div_tick && tx_tick == 4'hF)
         begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            o_txd <= next_tx_busy ? tx_shift[0] : 1'b1;
         end
         o_transceiver_drive_enable <= next_de_active ^ i_drive_enable_polarity;
         o_tx_holding_empty <= !next_hold_full;
         o_tx_empty <= !next_tx_busy && !next_tx_setup;
         o_tx_irq <= next_tx_irq && i_transmitter_on;
      end
   end

   // receiver: two-flop synchroniser, then 16x oversampled deserialiser
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end
      else if (i_ce)
      begin
         rxd_meta <= i_rxd;
         rxd_sync <= rxd_meta;
      end
   end

   always_comb
   begin
      next_rx_busy = rx_busy;
      next_rx_tick = rx_tick;
      next_rx_bits = rx_bits;
      next_rx_shift = rx_shift;
      rx_done = 1'b0;
      if (!rx_busy && i_receiver_on && !rxd_sync)
      begin
         next_rx_busy = 1'b1;
         next_rx_tick = uart_md_pkg::TICK_RESET;
         next_rx_bits = (i_ninebit_mode_enable || i_parity_enable) ? 4'hA : 4'h9;
      end
      else if (rx_busy && div_tick)
      begin
         next_rx_tick = rx_tick + 4'h1;
         if (rx_tick == uart_md_pkg::SAMPLE_MID)
         begin
            next_rx_shift = {rxd_sync, rx_shift[9:1]};
            if (rx_bits == 4'h0)
            begin
               next_rx_busy = 1'b0;
               rx_done = 1'b1;
            end
            else
            begin
               next_rx_bits = rx_bits - 4'h1;
            end
         end
      end
      // shift holds 10 bits for 9-bit frames; shorter frames keep the start bit in bit 0
      rx_char = (i_ninebit_mode_enable || i_parity_enable) ? next_rx_shift[8:0] : {1'b0, next_rx_shift[8:1]};
      rx_frame_bad = !next_rx_shift[9];
      rx_par_bad = i_parity_enable && !i_ninebit_mode_enable &&
         (parity_of(rx_char[7:0], i_parity_odd) != rx_char[8]);
      next_rx_err = {rx_char == 9'h000 && rx_frame_bad, rx_frame_bad, rx_par_bad};
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rx_busy <= 1'b0;
         rx_tick <= uart_md_pkg::TICK_RESET;
         rx_bits <= uart_md_pkg::BIT_RESET;
         rx_shift <= 10'h3FF;
         rx_err <= 3'h0;
      end
      else if (i_ce)
      begin
         rx_busy <= next_rx_busy;
         rx_tick <= next_rx_tick;
         rx_bits <= next_rx_bits;
         rx_shift <= next_rx_shift;
         if (rx_done)
         begin
            rx_err <= next_rx_err;
         end
      end
   end

   uart_md_fifo #(
      .WIDTH(uart_md_pkg::DATA_WIDTH),
      .DEPTH(uart_md_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_in_valid(rx_done),
      .i_in_data(rx_char),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_data),
      .i_out_ready(fifo_ready)
   );

   // filter and status; a full fifo drops the character and counts as overrun
   always_comb
   begin
      logic is_addr;
      logic match;
      logic accept;
      logic irq_data;
      is_addr = i_ninebit_mode_enable && fifo_data[8];
      match = fifo_data[7:0] == i_address_compare;
      accept = 1'b1;
      irq_data = 1'b1;
      fifo_ready = fifo_valid;
      next_frame_matched = frame_matched;
      next_want_first = want_first;
      next_rx_data = o_rx_data;
      next_avail = o_rx_byte_available;
      next_pe = o_parity_error;
      next_oe = o_overrun_error;
      next_fe = o_framing_error;
      next_brk = o_line_break_flag;
      next_marker = o_rx_marker_bit;
      next_first = o_first_byte_of_frame;
      next_pend_oe = pend_oe;
      next_pend_brk = pend_brk;
      if (i_rx_read)
      begin
         next_avail = pend_oe;
         next_oe = pend_oe;
         next_brk = pend_brk;
         next_pe = 1'b0;
         next_fe = 1'b0;
         next_marker = 1'b0;
         next_first = 1'b0;
         next_pend_oe = 1'b0;
         next_pend_brk = 1'b0;
      end
      if (i_ninebit_mode_enable)
      begin
         case (i_multidrop_scheme_select)
            uart_md_pkg::SCHEME_ALL:
            begin
               irq_data = 1'b1;
            end
            uart_md_pkg::SCHEME_ADDR_ONLY:
            begin
               irq_data = is_addr;
            end
            uart_md_pkg::SCHEME_MATCH_IRQ, uart_md_pkg::SCHEME_MATCH_QUIET:
            begin
               if (is_addr)
               begin
                  next_frame_matched = match;
                  next_want_first = match;
                  accept = match;
                  irq_data = (i_multidrop_scheme_select == uart_md_pkg::SCHEME_MATCH_IRQ);
               end
               else
               begin
                  accept = frame_matched;
               end
            end
            default:
            begin
               irq_data = 1'b1;
            end
         endcase
      end
      if (fifo_valid && accept)
      begin
         if (o_rx_byte_available && !i_rx_read)
         begin
            next_pend_oe = 1'b1;
            next_pend_brk = pend_brk || rx_err[2];
         end
         else
         begin
            next_rx_data = fifo_data[7:0];
            next_avail = irq_data || !i_ninebit_mode_enable;
            next_pe = rx_err[0];
            next_fe = rx_err[1];
            next_brk = rx_err[2];
            next_marker = fifo_data[8] && i_ninebit_mode_enable;
            next_first = want_first && !is_addr && i_multidrop_scheme_select[1];
            if (!is_addr)
            begin
               next_want_first = 1'b0;
            end
         end
      end
      next_rx_irq = (next_avail && i_rx_data_irq_enable) || next_oe || next_fe || next_brk ||
         (timer_mode && div_tick) || (i_divider_timer_enable && div_tick && timer_mode);
      if (!fifo_in_ready && rx_done)
      begin
         next_pend_oe = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         frame_matched <= 1'b0;
         want_first <= 1'b0;
         pend_oe <= 1'b0;
         pend_brk <= 1'b0;
         o_rx_data <= uart_md_pkg::BYTE_RESET;
         o_rx_byte_available <= 1'b0;
         o_parity_error <= 1'b0;
         o_overrun_error <= 1'b0;
         o_framing_error <= 1'b0;
         o_line_break_flag <= 1'b0;
         o_rx_marker_bit <= 1'b0;
         o_first_byte_of_frame <= 1'b0;
         o_rx_irq <= 1'b0;
      end
      else if (i_ce)
      begin
         frame_matched <= next_frame_matched;
         want_first <= next_want_first;
         pend_oe <= next_pend_oe;
         pend_brk <= next_pend_brk;
         o_rx_data <= next_rx_data;
         o_rx_byte_available <= next_avail;
         o_parity_error <= next_pe;
         o_overrun_error <= next_oe;
         o_framing_error <= next_fe;
         o_line_break_flag <= next_brk;
         o_rx_marker_bit <= next_marker;
         o_first_byte_of_frame <= next_first;
         o_rx_irq <= next_rx_irq;
      end
   end

   property p_write_clears_empty;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && i_tx_write) |=> !o_tx_holding_empty;
   endproperty
   a_write_clears_empty: assert property (p_write_clears_empty) else $error("holding empty not cleared");

   property p_de_before_start;
      @(posedge i_clk) disable iff (!i_rst_b)
      ($fell(o_txd) && tx_busy) |-> $past(de_active);
   endproperty
   a_de_before_start: assert property (p_de_before_start) else $error("drive enable late");

   property p_de_polarity;
      @(posedge i_clk) disable iff (!i_rst_b)
      i_ce && $stable(i_drive_enable_polarity) |=>
         (o_transceiver_drive_enable == (de_active ^ $past(i_drive_enable_polarity)));
   endproperty
   a_de_polarity: assert property (p_de_polarity) else $error("drive enable polarity wrong");

   property p_read_clears;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && i_rx_read && !fifo_valid) |=> !o_parity_error && !o_framing_error && !o_rx_marker_bit;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

   property p_overrun_hidden;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && $rose(pend_oe) && !i_rx_read) |-> !o_overrun_error;
   endproperty
   a_overrun_hidden: assert property (p_overrun_hidden) else $error("overrun shown early");

   property p_overrun_after_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && i_rx_read && pend_oe && !fifo_valid) |=> o_overrun_error && o_rx_byte_available;
   endproperty
   a_overrun_after_read: assert property (p_overrun_after_read) else $error("overrun not shown");

   property p_filter_drop;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && fifo_valid && i_ninebit_mode_enable && i_multidrop_scheme_select[1] && !fifo_data[8]
         && !frame_matched && !i_rx_read) |=> $stable(o_rx_data);
   endproperty
   a_filter_drop: assert property (p_filter_drop) else $error("unmatched data accepted");

   property p_divider_reload;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && div_tick && $stable(i_bit_rate_divider)) |=> (div_cnt == $past(i_bit_rate_divider));
   endproperty
   a_divider_reload: assert property (p_divider_reload) else $error("divider did not reload");
endmodule : uart_multidrop_de_brg

/* File: uart_md_node.sv */
// far node model: bit-timed sender sharing the pair with the block
`timescale 1ns/100ps
module uart_md_node #(
   parameter int BIT_CLKS = 16
) (
   // clocking
   input wire logic i_clk,
   // block side of the pair
   input wire logic i_de,
   input wire logic i_txd,
   // level every receiver sees
   output logic o_line
);
   logic drv = 1'b0;
   logic lvl = 1'b1;
   // failsafe bias holds an undriven pair at idle mark
   assign o_line = i_de ? i_txd : (drv ? lvl : 1'b1);
   task automatic send(input logic [8:0] v);
      logic [10:0] f;
      f = {1'b1, v, 1'b0};
      drv = 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         lvl = f[i];
         repeat (BIT_CLKS) @(posedge i_clk);
         #1;
      end
      drv = 1'b0;
   endtask : send
endmodule : uart_md_node

/* File: uart_multidrop_de_brg_tb_top.sv */
// self-checking bench for the multidrop uart extension
`timescale 1ns/100ps
module uart_multidrop_de_brg_tb_top;
   logic i_clk = 0, i_rst_b = 0, en = 0, wr = 0, rd = 0, mark = 0, pol = 0;
   logic [1:0] scheme = 2'h0;
   logic [7:0] txb = 8'h00, addr = 8'h5A, rx_data;
   logic [15:0] div = 16'h0000;
   logic de, txd, line, avail, fbf, mk, the, txe, tirq, rirq;
   logic [9:0] q[$];
   integer seed = 32'h3CAD971C, error_cnt = 0, n_tests = 0, cyc = 0, cnt;
   uart_md_node #(.BIT_CLKS(16)) u_node (.i_clk(i_clk), .i_de(de ^ pol), .i_txd(txd), .o_line(line));
   uart_multidrop_de_brg u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_transmitter_on(en),
      .i_receiver_on(en), .i_parity_enable(1'b0), .i_parity_odd(1'b0), .i_two_stop(1'b0),
      .i_ninebit_mode_enable(en), .i_multidrop_scheme_select(scheme), .i_tx_marker_bit(mark),
      .i_address_compare(addr), .i_drive_enable_polarity(pol), .i_divider_timer_enable(~en),
      .i_rx_data_irq_enable(en), .i_bit_rate_divider(div), .i_tx_write(wr), .i_tx_data(txb),
      .i_rx_read(rd), .i_rxd(line), .o_txd(txd), .o_transceiver_drive_enable(de), .o_rx_data(rx_data),
      .o_rx_byte_available(avail), .o_parity_error(), .o_overrun_error(), .o_framing_error(),
      .o_line_break_flag(), .o_tx_holding_empty(the), .o_tx_empty(txe), .o_rx_marker_bit(mk),
      .o_first_byte_of_frame(fbf), .o_tx_irq(tirq), .o_rx_irq(rirq));
   initial forever #2.5 i_clk = ~i_clk;
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // each byte the block flags as available is matched against the oldest note, then read away
   initial forever
   begin
      @(posedge i_clk);
      #1;
      if (avail === 1'b1)
      begin
         check({fbf, mk, rx_data}, q.size() ? q.pop_front() : 10'h3FF);
         rd = 1;
         @(posedge i_clk);
         #1 rd = 0;
      end
   end
   task automatic xfer(input logic [8:0] v, input logic keep, input logic first);
      if (keep)
         q.push_back({first, v});
      u_node.send(v);
      repeat (40) @(posedge i_clk);
      #1;
   endtask : xfer
   task automatic put(input logic [8:0] v);
      {mark, txb} = v;
      wr = 1;
      @(posedge i_clk);
      #1 wr = 0;
   endtask : put
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (10) @(posedge i_clk);
      #1 i_rst_b = 1;
      check({de, txd, the}, 10'h3);
      en = 1;
      pol = 1;
      div = 16'h0001;
      addr = 8'($random(seed));
      for (int i = 0; i < 4; i++)
         xfer(9'($random(seed)), 1, 0);
      check({de, tirq}, 10'h3);
      pol = 0;
      scheme = 2'h2;
      xfer({1'b1, addr}, 1, 0);
      xfer(9'h0C3, 1, 1);
      xfer(9'h03C, 1, 0);
      xfer({1'b1, ~addr}, 0, 0);
      xfer(9'h077, 0, 0);
      scheme = 2'h1;
      xfer(9'h1A5, 1, 0);
      xfer(9'h0A5, 0, 0);
      scheme = 2'h3;
      xfer({1'b1, addr}, 0, 0);
      xfer(9'h066, 1, 1);
      scheme = 2'h0;
      cnt = $random(seed);
      q.push_back({1'b0, 9'(cnt)});
      q.push_back({1'b0, ~9'(cnt)});
      put(9'(cnt));
      check({de, the}, 10'h2);
      cnt = 0;
      while (txd !== 1'b0 && cnt < 100)
      begin
         @(posedge i_clk);
         #1 cnt++;
      end
      check(10'(cnt > 15 && cnt < 33), 10'h1);
      while (the !== 1'b1 && cnt < 400)
      begin
         @(posedge i_clk);
         #1 cnt++;
      end
      check(10'(cnt > 31 && cnt < 49), 10'h1);
      check({the, tirq}, 10'h3);
      put(q[q.size()-1][8:0]);
      cnt = 0;
      // a gap at the character boundary would cut this count roughly in half
      while (de === 1'b1 && cnt < 1000)
      begin
         @(posedge i_clk);
         #1 cnt++;
      end
      check(10'(cnt > 300 && cnt < 420), 10'h1);
      check({de, txd, txe}, 10'h3);
      repeat (300) @(posedge i_clk);
      #1 check(10'(q.size()), 10'h0);
      en = 0;
      div = 16'h0009;
      repeat (30) @(posedge i_clk);
      #1 cnt = 0;
      while (rirq !== 1'b1 && cnt < 40)
      begin
         @(posedge i_clk);
         #1 cnt++;
      end
      @(posedge i_clk);
      #1 cnt = 1;
      while (rirq !== 1'b1 && cnt < 40)
      begin
         @(posedge i_clk);
         #1 cnt++;
      end
      check(10'(cnt), 10'(div));
      tally_and_finish();
   end
endmodule : uart_multidrop_de_brg_tb_top
